// [src/sbd_defines.vh]
// Shared constants for the subtract datapath: opcodes, register map,
// status bit positions, reset values and phase codes.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef SBD_DEFINES_VH
`define SBD_DEFINES_VH

// Opcode fields
`define SBD_OP_REVSUB 6'h15
`define SBD_OP_FILESUB 6'h17
`define SBD_OP_LITSUB 8'h08
`define SBD_DEST_BIT 9
`define SBD_BANK_BIT 8

// Internal operation codes
`define SBD_OPC_REVSUB 2'h0
`define SBD_OPC_FILESUB 2'h1
`define SBD_OPC_LITSUB 2'h2

// Register port addresses
`define SBD_REG_ACC 3'h0
`define SBD_REG_STATUS 3'h1
`define SBD_REG_BANK 3'h2
`define SBD_REG_CTRL 3'h3
`define SBD_REG_IDX_LO 3'h4
`define SBD_REG_IDX_HI 3'h5
`define SBD_REG_RESULT 3'h6
`define SBD_REG_STATE 3'h7

// Status bit positions
`define SBD_ST_C 0
`define SBD_ST_DC 1
`define SBD_ST_Z 2
`define SBD_ST_OV 3
`define SBD_ST_N 4
`define SBD_ST_ARITH_MASK 8'h1F

// Reset values
`define SBD_RST_ACC 8'h00
`define SBD_RST_STATUS 8'h00
`define SBD_RST_BANK 4'h0
`define SBD_RST_IDX 12'h000

// Addressing
`define SBD_ILO_LIMIT 8'h5F
`define SBD_ACCESS_SPLIT 8'h60
`define SBD_ACCESS_HIGH 4'hF
`define SBD_ACCESS_LOW 4'h0

// Phase codes of the instruction cycle
`define SBD_PH_Q1 2'h0
`define SBD_PH_Q2 2'h1
`define SBD_PH_Q3 2'h2
`define SBD_PH_Q4 2'h3

`endif

// [src/sbd_phase.v]
// Four-phase generator: splits the clock into Q1..Q4 enables.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ns
`include "sbd_defines.vh"
module sbd_phase (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Phase outputs
  output reg [1:0] phase_o,
  output wire q1_o,
  output wire q2_o,
  output wire q3_o,
  output wire q4_o
);

  // Free-running phase counter, Q1 after reset
  always @(posedge clk_i) begin
    if (reset_i) begin
      phase_o <= `SBD_PH_Q1;
    end else begin
      phase_o <= phase_o + 2'h1;
    end
  end

  // One-cycle enables, one per phase
  assign q1_o = (phase_o == `SBD_PH_Q1);
  assign q2_o = (phase_o == `SBD_PH_Q2);
  assign q3_o = (phase_o == `SBD_PH_Q3);
  assign q4_o = (phase_o == `SBD_PH_Q4);

endmodule // sbd_phase

// [src/sbd_subalu.v]
// Byte subtractor: minuend - subtrahend - borrow with five flags.
// Purely combinational; the caller registers the outputs.
`timescale 1ns/1ns
module sbd_subalu #(
  parameter W = 8
) (
  // Operands
  input wire [W-1:0] min_i,
  input wire [W-1:0] sub_i,
  input wire borrow_i,
  // Result and flags
  output wire [W-1:0] res_o,
  output wire c_o,
  output wire dc_o,
  output wire z_o,
  output wire ov_o,
  output wire n_o
);

  wire [W:0] full_diff;
  wire [4:0] low_diff;

  // Full and low-nibble differences with borrow
  assign full_diff = {1'b0, min_i} - {1'b0, sub_i} - {{W{1'b0}}, borrow_i};
  assign low_diff = {1'b0, min_i[3:0]} - {1'b0, sub_i[3:0]}
                    - {4'h0, borrow_i};
  assign res_o = full_diff[W-1:0];

  // Carry is inverted borrow
  assign c_o = ~full_diff[W];
  assign dc_o = ~low_diff[4];
  assign z_o = (res_o == {W{1'b0}});
  assign n_o = res_o[W-1];
  // Signed overflow: operands differ in sign, result sign follows subtrahend
  assign ov_o = (min_i[W-1] ^ sub_i[W-1]) & (min_i[W-1] ^ res_o[W-1]);

endmodule // sbd_subalu

// [src/sbd_datapath.v]
// Subtract datapath: decodes and executes the three byte subtracts
// over a four-phase instruction cycle, with banked memory addressing.
// Assumes the decoder offers an instruction in Q1 and memory returns
// read data in the cycle after its read strobe. A software write to STATUS
// in a commit cycle is lost, as is one to ACC when dest is acc; the commit wins.
//
// Operation
// - Reverse subtract: acc minus reg minus not-carry
// - Decode reverse subtract from 010101 d a f
// - Decode 010111 d a f: reg minus acc
// - Opcode 08h: literal minus acc into acc
// - Update N OV C DC Z only
// - Carry set unless borrow; Z zero; N negative
// - Dest bit 0 acc, 1 back to register
// - Bank bit 0 uses access bank, ignores bank
// - Bank bit 1: bank register plus address
// - Extended mode, low addresses use indexed offset
// - One word, one cycle, four phases
`timescale 1ns/1ns
`include "sbd_defines.vh"
module sbd_datapath #(
  parameter AW = 12,
  parameter DW = 8
) (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Instruction from decoder
  input wire [15:0] instr_i,
  input wire instr_valid_i,
  // Register port
  input wire [2:0] reg_addr_i,
  input wire [DW-1:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [DW-1:0] reg_rdata_o,
  // Data memory
  output reg [AW-1:0] mem_addr_o,
  output reg mem_rd_o,
  output reg mem_wr_o,
  output reg [DW-1:0] mem_wdata_o,
  input wire [DW-1:0] mem_rdata_i,
  // Cycle status
  output wire [1:0] phase_o,
  output reg busy_o,
  output reg done_o,
  output reg reject_o
);

  // Software-visible state
  reg [DW-1:0] acc_r;
  reg [DW-1:0] status_r;
  reg [3:0] bank_r;
  reg ext_en_r;
  reg [AW-1:0] idx_base_r;

  // Instruction in flight
  reg [1:0] op_r;
  reg dest_r;
  reg [DW-1:0] lit_r;
  reg [DW-1:0] res_r;
  reg [4:0] flags_r;

  // Phase enables
  wire q1;
  wire q2;
  wire q3;
  wire q4;

  // Decode wires
  wire is_rev;
  wire is_file;
  wire is_lit;
  wire is_sub;
  wire [1:0] op_nxt;
  wire dest_bit;
  wire bank_bit;
  wire [7:0] f_field;
  reg [AW-1:0] addr_nxt;

  // Addressing mode qualifiers
  wire use_index;
  wire low_access;

  // Write sources for accumulator, status and register destination
  wire hw_commit;
  wire hw_acc_wr;
  wire sw_acc_wr;
  wire sw_status_wr;
  wire wr_back;

  // Subtractor wires
  wire [DW-1:0] operand;
  wire [DW-1:0] alu_min;
  wire [DW-1:0] alu_sub;
  wire alu_borrow;
  wire [DW-1:0] alu_res;
  wire alu_c;
  wire alu_dc;
  wire alu_z;
  wire alu_ov;
  wire alu_n;
  wire [DW-1:0] status_nxt;

  // Phase generator
  sbd_phase u_phase (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .phase_o(phase_o),
    .q1_o(q1),
    .q2_o(q2),
    .q3_o(q3),
    .q4_o(q4)
  );

  // Opcode decode
  assign is_rev = (instr_i[15:10] == `SBD_OP_REVSUB);
  assign is_file = (instr_i[15:10] == `SBD_OP_FILESUB);
  assign is_lit = (instr_i[15:8] == `SBD_OP_LITSUB);
  assign is_sub = is_rev | is_file | is_lit;
  assign op_nxt = is_lit ? `SBD_OPC_LITSUB :
                  (is_file ? `SBD_OPC_FILESUB : `SBD_OPC_REVSUB);
  assign dest_bit = instr_i[`SBD_DEST_BIT];
  assign bank_bit = instr_i[`SBD_BANK_BIT];
  assign f_field = instr_i[7:0];

  // Indexed window only with bank bit clear and extended mode on
  assign use_index = ext_en_r && (f_field <= `SBD_ILO_LIMIT);
  assign low_access = (f_field < `SBD_ACCESS_SPLIT);

  // Data memory address from bank bit, bank and extended mode
  always @* begin
    if (bank_bit) begin
      addr_nxt = {bank_r, f_field};
    end else if (use_index) begin
      addr_nxt = idx_base_r + {4'h0, f_field};
    end else if (low_access) begin
      addr_nxt = {`SBD_ACCESS_LOW, f_field};
    end else begin
      addr_nxt = {`SBD_ACCESS_HIGH, f_field};
    end
  end

  // Operand selection and operand order per operation
  assign operand = (op_r == `SBD_OPC_LITSUB) ? lit_r : mem_rdata_i;
  assign alu_min = (op_r == `SBD_OPC_REVSUB) ? acc_r : operand;
  assign alu_sub = (op_r == `SBD_OPC_REVSUB) ? operand : acc_r;
  assign alu_borrow = (op_r == `SBD_OPC_REVSUB) &
                      ~status_r[`SBD_ST_C];

  // Byte subtractor
  sbd_subalu #(
    .W(DW)
  ) u_alu (
    .min_i(alu_min),
    .sub_i(alu_sub),
    .borrow_i(alu_borrow),
    .res_o(alu_res),
    .c_o(alu_c),
    .dc_o(alu_dc),
    .z_o(alu_z),
    .ov_o(alu_ov),
    .n_o(alu_n)
  );

  // Arithmetic flags replace only their own bits
  assign status_nxt = (status_r & ~`SBD_ST_ARITH_MASK) |
                      {3'h0, flags_r};

  // Q1 decode, Q2 read, Q3 process, Q4 write
  always @(posedge clk_i) begin
    if (reset_i) begin
      busy_o <= 1'b0;
      op_r <= `SBD_OPC_REVSUB;
      dest_r <= 1'b0;
      lit_r <= 8'h00;
      mem_addr_o <= {AW{1'b0}};
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_wdata_o <= 8'h00;
      res_r <= 8'h00;
      flags_r <= 5'h00;
      done_o <= 1'b0;
      reject_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      reject_o <= 1'b0;
      // Decode phase takes one word
      if (q1 && instr_valid_i) begin
        if (is_sub) begin
          busy_o <= 1'b1;
          op_r <= op_nxt;
          dest_r <= is_lit ? 1'b0 : dest_bit;
          lit_r <= f_field;
          mem_addr_o <= addr_nxt;
          mem_rd_o <= ~is_lit;
        end else begin
          reject_o <= 1'b1;
        end
      end
      // Read phase: strobe stands for Q2 only
      if (q2) begin
        mem_rd_o <= 1'b0;
      end
      // Process phase: data from memory or literal
      if (q3 && busy_o) begin
        res_r <= alu_res;
        flags_r[`SBD_ST_C] <= alu_c;
        flags_r[`SBD_ST_DC] <= alu_dc;
        flags_r[`SBD_ST_Z] <= alu_z;
        flags_r[`SBD_ST_OV] <= alu_ov;
        flags_r[`SBD_ST_N] <= alu_n;
        mem_wdata_o <= alu_res;
        mem_wr_o <= wr_back;
      end
      // Write phase ends the instruction
      if (q4) begin
        mem_wr_o <= 1'b0;
        if (busy_o) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

  // Commit in Q4 outranks a software write landing in the same cycle
  assign hw_commit = q4 && busy_o;
  assign hw_acc_wr = hw_commit && !dest_r;
  assign wr_back = dest_r & (op_r != `SBD_OPC_LITSUB);
  assign sw_acc_wr = reg_wr_i && (reg_addr_i == `SBD_REG_ACC);
  assign sw_status_wr = reg_wr_i && (reg_addr_i == `SBD_REG_STATUS);

  // Accumulator: hardware write in Q4 wins over software
  always @(posedge clk_i) begin
    if (reset_i) begin
      acc_r <= `SBD_RST_ACC;
    end else if (hw_acc_wr) begin
      acc_r <= res_r;
    end else if (sw_acc_wr) begin
      acc_r <= reg_wdata_i;
    end
  end

  // Status: flag commit in Q4 wins over software
  always @(posedge clk_i) begin
    if (reset_i) begin
      status_r <= `SBD_RST_STATUS;
    end else if (hw_commit) begin
      status_r <= status_nxt;
    end else if (sw_status_wr) begin
      status_r <= reg_wdata_i;
    end
  end

  // Configuration registers
  always @(posedge clk_i) begin
    if (reset_i) begin
      bank_r <= `SBD_RST_BANK;
      ext_en_r <= 1'b0;
      idx_base_r <= `SBD_RST_IDX;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `SBD_REG_BANK: begin
          bank_r <= reg_wdata_i[3:0];
        end
        `SBD_REG_CTRL: begin
          ext_en_r <= reg_wdata_i[0];
        end
        `SBD_REG_IDX_LO: begin
          idx_base_r[7:0] <= reg_wdata_i;
        end
        `SBD_REG_IDX_HI: begin
          idx_base_r[AW-1:8] <= reg_wdata_i[AW-9:0];
        end
        default: begin
          bank_r <= bank_r;
        end
      endcase
    end
  end

  // Read data in the cycle after the strobe, zero otherwise
  always @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `SBD_REG_ACC: reg_rdata_o <= acc_r;
        `SBD_REG_STATUS: reg_rdata_o <= status_r;
        `SBD_REG_BANK: reg_rdata_o <= {4'h0, bank_r};
        `SBD_REG_CTRL: reg_rdata_o <= {7'h00, ext_en_r};
        `SBD_REG_IDX_LO: reg_rdata_o <= idx_base_r[7:0];
        `SBD_REG_IDX_HI: reg_rdata_o <= {4'h0, idx_base_r[AW-1:8]};
        `SBD_REG_RESULT: reg_rdata_o <= res_r;
        `SBD_REG_STATE: reg_rdata_o <= {3'h0, busy_o, dest_r, op_r,
                                        mem_wr_o};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule // sbd_datapath

// [sim/sbd_mem_model.sv]
// Data memory model on the far side of the datapath, 4K bytes.
// Assumes registered strobes; read data stand one cycle after mem_rd_i.
`timescale 1ns/1ns
module sbd_mem_model (
  // Clock
  input wire clk_i,
  // Memory port
  input wire [11:0] mem_addr_i,
  input wire mem_rd_i,
  input wire mem_wr_i,
  input wire [7:0] mem_wdata_i,
  output reg [7:0] mem_rdata_o
);
  reg [7:0] mem [0:4095];
  initial mem_rdata_o = 8'h00;
  // Read for one cycle, else flip so stale data never looks valid
  always @(posedge clk_i) begin
    if (mem_rd_i)
      mem_rdata_o <= mem[mem_addr_i];
    else
      mem_rdata_o <= ~mem_rdata_o;
    if (mem_wr_i)
      mem[mem_addr_i] <= mem_wdata_i;
  end
endmodule // sbd_mem_model

// [sim/sbd_dp_properties.sv]
// Port-timing checker for the subtract datapath.
// Assumes it is bound onto sbd_datapath with default widths.
`timescale 1ns/1ns
module sbd_dp_properties (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Watched ports
  input wire [15:0] instr_i,
  input wire instr_valid_i,
  input wire [11:0] mem_addr_o,
  input wire mem_rd_o,
  input wire mem_wr_o,
  input wire [1:0] phase_o,
  input wire busy_o,
  input wire done_o,
  input wire reject_o
);
  // Opcode classes
  wire lit = instr_i[15:8] == 8'h08;
  wire rsub = instr_i[15:10] == 6'h15 || instr_i[15:10] == 6'h17;
  wire q1v = phase_o == 2'h0 && instr_valid_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Accepted subtract and its cycle
  sequence s_take;
    q1v && (lit || rsub);
  endsequence
  sequence s_rtake;
    q1v && rsub;
  endsequence
  sequence s_cycle;
    busy_o [*3] ##1 done_o && !busy_o;
  endsequence
  chk_reset_q1: assert property (reset_i
    |=> phase_o == 2'h0 && !busy_o) else $error("reset did not end in Q1");
  chk_phase_walk: assert property (!reset_i && phase_o == 2'h0
    |=> phase_o == 2'h1 ##1 phase_o == 2'h2 ##1 phase_o == 2'h3
    ##1 phase_o == 2'h0) else $error("phase sequence broken");
  chk_busy_done: assert property (s_take |=> s_cycle)
    else $error("busy or done timing wrong");
  chk_read_q2: assert property (s_rtake |=> mem_rd_o ##1 !mem_rd_o)
    else $error("operand read not in Q2");
  chk_lit_noread: assert property (s_take ##0 lit
    |=> (!mem_rd_o && !mem_wr_o) [*3]) else $error("literal used memory");
  chk_reg_dest: assert property (s_rtake ##0 instr_i[9]
    |-> ##3 mem_wr_o) else $error("register destination not written");
  chk_acc_dest: assert property (s_rtake ##0 !instr_i[9]
    |=> !mem_wr_o [*3]) else $error("memory written for acc destination");
  chk_bank_addr: assert property (s_rtake ##0 instr_i[8]
    |=> mem_addr_o[7:0] == $past(instr_i[7:0])) else $error("bank addr");
  chk_access_hi: assert property (s_rtake ##0 !instr_i[8]
    && instr_i[7:0] >= 8'h60 |=> mem_addr_o == {4'hF, $past(instr_i[7:0])})
    else $error("access bank address wrong");
  chk_reject_q2: assert property (q1v && !lit && !rsub
    |=> reject_o && !busy_o) else $error("unknown word not refused");
endmodule // sbd_dp_properties
bind sbd_datapath sbd_dp_properties u_chk (.clk_i, .reset_i, .instr_i,
  .instr_valid_i, .mem_addr_o, .mem_rd_o, .mem_wr_o, .phase_o, .busy_o,
  .done_o, .reject_o);

// [sim/sbd_datapath_tb_top.sv]
// Self-checking bench for the subtract datapath.
// Assumes sbd_mem_model as memory; the checker is bound separately.
`timescale 1ns/1ns
module sbd_datapath_tb_top;
  reg clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg [15:0] instr_i = 16'h0000;
  reg instr_valid_i = 1'b0;
  reg [2:0] reg_addr_i = 3'h0;
  reg [7:0] reg_wdata_i = 8'h00;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  wire [7:0] reg_rdata_o, mem_wdata_o, mem_rdata_i;
  wire [11:0] mem_addr_o;
  wire mem_rd_o, mem_wr_o, busy_o, done_o, reject_o;
  wire [1:0] phase_o;
  integer fail_count = 0;
  integer check_count = 0;
  integer i, j;
  reg [31:0] r;
  reg [7:0] acc, st, bank, f, k, v;
  reg [11:0] idx, adr;
  reg [1:0] op;
  reg d, a, ext;
  reg [12:0] e;
  // Clock, 10 ns
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  sbd_datapath u_sbd_datapath (.clk_i, .reset_i, .instr_i, .instr_valid_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .mem_addr_o, .mem_rd_o, .mem_wr_o, .mem_wdata_o, .mem_rdata_i,
    .phase_o, .busy_o, .done_o, .reject_o);
  sbd_mem_model u_mem (.clk_i, .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
    .mem_wr_i(mem_wr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [2:0] ad, input [7:0] dt);
    begin
      @(posedge clk_i);
      reg_addr_i <= ad;
      reg_wdata_i <= dt;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  task rd(input [2:0] ad, output [7:0] dv);
    begin
      @(posedge clk_i);
      reg_addr_i <= ad;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      @(negedge clk_i);
      dv = reg_rdata_o;
    end
  endtask
  // Offer one word in Q1 and follow its cycle
  task run(input [15:0] iw, input bad);
    begin
      @(negedge clk_i);
      for (j = 0; j < 4 && phase_o !== 2'h3; j = j + 1) @(negedge clk_i);
      @(posedge clk_i);
      instr_i <= iw;
      instr_valid_i <= 1'b1;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      @(negedge clk_i);
      chk(reject_o, bad);
      chk(mem_rd_o, !bad && op != 2'h2);
      repeat (2) @(negedge clk_i);
      chk(mem_wr_o, !bad && d && op != 2'h2);
      @(negedge clk_i);
      chk(done_o, !bad);
    end
  endtask
  // Expected {N, OV, Z, DC, C, result}
  function [12:0] model(input [1:0] o, input [7:0] ac, fv, input c);
    reg [7:0] mn, sb;
    reg b;
    reg [8:0] df;
    reg [4:0] dn;
    begin
      mn = (o == 2'h0) ? ac : fv;
      sb = (o == 2'h0) ? fv : ac;
      b = (o == 2'h0) ? !c : 1'b0;
      df = {1'b0, mn} - {1'b0, sb} - b;
      dn = {1'b0, mn[3:0]} - {1'b0, sb[3:0]} - b;
      model = {df[7], (mn[7] != sb[7]) && (df[7] != mn[7]),
        df[7:0] == 8'h00, !dn[4], !df[8], df[7:0]};
    end
  endfunction
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    #200000;
    fail_count = fail_count + 1;
    tally_and_finish;
  end
  // Random subtracts, first four on the indexed boundary
  initial begin
    r = $urandom(32'h71d77ed5);
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    for (i = 0; i < 64; i = i + 1) begin
      op = 2'($urandom % 3);
      {acc, st, bank, f} = $urandom;
      r = $urandom;
      {k, idx, d, a, ext} = r[22:0];
      if (i < 4) begin
        f = i[0] ? 8'h5F : 8'h60;
        a = 1'b0;
        ext = 1'b1;
        op = 2'h1;
      end
      wr(3'h0, acc);
      wr(3'h1, st);
      wr(3'h2, bank);
      wr(3'h3, {7'h00, ext});
      wr(3'h4, idx[7:0]);
      wr(3'h5, {4'h0, idx[11:8]});
      adr = a ? {bank[3:0], f} : (ext && f <= 8'h5F) ? idx + f
        : {f < 8'h60 ? 4'h0 : 4'hF, f};
      u_mem.mem[adr] = k;
      e = model(op, acc, op == 2'h2 ? f : k, st[0]);
      run(op == 2'h2 ? {8'h08, f} : {4'h5, op[0] ? 2'h3 : 2'h1, d, a, f},
        1'b0);
      wr(3'h6, ~e[7:0]);
      rd(3'h6, v);
      chk(v, e[7:0]);
      rd(3'h1, v);
      chk(v, {st[7:5], e[12:8]});
      rd(3'h0, v);
      chk(v, (d && op != 2'h2) ? acc : e[7:0]);
      chk(u_mem.mem[adr],
        (d && op != 2'h2) ? e[7:0] : k);
    end
    run(16'h0003, 1'b1);
    tally_and_finish;
  end
endmodule // sbd_datapath_tb_top
